// ==== rtl/dsp_crc_cfg.svh ====
`ifndef DSP_CRC_CFG_SVH
`define DSP_CRC_CFG_SVH

// ============================================================
// Register byte offsets on the Avalon-MM slave.
`define OFS_AUTOBUF_CTRL 5'h00
`define OFS_MODE_STATUS 5'h04
`define OFS_INT_MASK 5'h08
`define OFS_SYS_CTRL 5'h0C
`define OFS_STACK_PTRS 5'h10
`define OFS_SEQ_STATUS 5'h14

// ============================================================
// Field positions and writable masks.
`define CLOCK_OUTPUT_DISABLE_BIT 14
`define AUTOBUF_MASK 16'h7FFF
`define MODE_STATUS_MASK 16'h007F
`define IMASK_MASK 16'h03FF
`define SYS_CTRL_MASK 16'h1FFF
`define SYS_SIX_IRQ_BIT 12
`define WAIT_FIELD_W 3

// ============================================================
// Reset values.
`define AUTOBUF_RST 16'h0000
`define MODE_STATUS_RST 16'h0000
`define IMASK_RST 16'h0000
`define SYS_CTRL_RST 16'h0000
`define STACK_EMPTY 16'h0000
`define RESET_VECTOR 14'h0000

// ============================================================
// Lock count in input clock cycles, and the cycle clock phase pattern.
`define PLL_LOCK_CYCLES 12'h7D0
`define CYCLE_CLOCK_PATTERN 4'hA

`endif

// ==== rtl/dsp_crc_pkg.sv ====
package dsp_crc_pkg;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_BOOT,
        ST_FETCH,
        ST_RUN,
        ST_PWRDN
    } seq_state_e;

    typedef logic [15:0] reg16_t;
    typedef logic [13:0] addr14_t;

endpackage : dsp_crc_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] dout_ff;

    // ============================================================
    // Two stages; the first stage feeds nothing but the second.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= INIT;
            dout_ff <= INIT;
        end else if (ce) begin
            meta_ff <= din;
            dout_ff <= meta_ff;
        end
    end

    assign dout = dout_ff;

endmodule : pin_sync

// ==== rtl/wait_stretch.sv ====
`timescale 1ns/1ps

module wait_stretch (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic start,
    input wire logic [2:0] waits,
    output logic busy,
    output logic done
);

    logic [2:0] cnt_ff;
    logic busy_ff;
    logic done_ff;

    // ============================================================
    // One base cycle plus the programmed number of wait states.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 3'h0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= busy_ff && (cnt_ff == 3'h0);
            if (start && !busy_ff) begin
                busy_ff <= 1'b1;
                cnt_ff <= waits;
            end else if (busy_ff && cnt_ff == 3'h0) begin
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff - 3'h1;
            end
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;

endmodule : wait_stretch

// ==== rtl/dsp_clock_reset_control.sv ====
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "dsp_crc_cfg.svh"

module dsp_clock_reset_control (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic reset_pin_n,
    input wire logic bus_request_n,
    input wire logic boot_strap,
    input wire logic host_strap,
    input wire logic power_down_n,
    input wire logic [3:0] irq_pins,
    input wire logic [1:0] shared_pins,
    input wire logic boot_done,
    input wire logic ext_req,
    input wire logic [1:0] ext_space,
    input wire dsp_crc_pkg::addr14_t ext_addr,
    output logic master_reset,
    output logic boot_start,
    output logic fetch_start,
    output dsp_crc_pkg::addr14_t fetch_addr,
    output logic [3:0] cycle_clock_output,
    output logic [1:0] instr_slots,
    output logic power_down_ack,
    output logic [5:0] irq_req,
    output logic [1:0] sport1_in,
    output logic sport1_enable,
    output logic ext_ack,
    output logic ext_strobe_n,
    output dsp_crc_pkg::addr14_t ext_addr_pin,
    output dsp_crc_pkg::addr14_t ext_addr_oe_n
);
    import dsp_crc_pkg::*;

    // ============================================================
    // Pin synchronisers.
    logic [10:0] pins_s;
    logic pin_rst_n_s;
    logic bus_req_n_s;
    logic boot_strap_s;
    logic host_strap_s;
    logic pwd_n_s;
    logic [3:0] irq_s;
    logic [1:0] shared_s;

    // The reset pin starts low in the chain so no boot can begin early.
    pin_sync #(.W(11), .INIT(11'h01A)) u_pins (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .din({shared_pins, irq_pins, power_down_n, host_strap, boot_strap,
              bus_request_n, reset_pin_n}),
        .dout(pins_s)
    );

    assign pin_rst_n_s = pins_s[0];
    assign bus_req_n_s = pins_s[1];
    assign boot_strap_s = pins_s[2];
    assign host_strap_s = pins_s[3];
    assign pwd_n_s = pins_s[4];
    assign irq_s = pins_s[8:5];
    assign shared_s = pins_s[10:9];

    // ============================================================
    // Lock tracking and master reset.
    logic [11:0] lock_cnt_ff;
    logic locked_ff;
    logic mrst;

    // Only the supply-level reset clears the lock, so a pin reset later
    // on leaves the clock running and costs no stabilisation time.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lock_cnt_ff <= 12'h000;
            locked_ff <= 1'b0;
        end else if (ce && !locked_ff) begin
            lock_cnt_ff <= lock_cnt_ff + 12'h001;
            locked_ff <= (lock_cnt_ff == `PLL_LOCK_CYCLES - 12'h001);
        end
    end

    assign mrst = !pin_rst_n_s || !locked_ff;
    assign master_reset = mrst;

    // ============================================================
    // Avalon-MM slave: one wait state on every access.
    reg16_t autobuf_ff;
    reg16_t mode_status_ff;
    reg16_t imask_ff;
    reg16_t sys_ctrl_ff;
    reg16_t stack_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic access;
    logic wr_take;
    logic sel_ab;
    logic sel_ms;
    logic sel_im;
    logic sel_sc;
    logic sel_sp;
    logic sel_st;
    logic [15:0] be_mask;
    logic [15:0] wdata;
    logic [15:0] rd_mux;
    logic [15:0] seq_status;
    seq_state_e state_ff;
    logic host_mode_ff;
    logic boot_cfg_ff;

    assign access = avs_read || avs_write;
    assign avs_waitrequest = access && !(ack_ff && ce);
    assign wr_take = avs_write && ack_ff && ce;
    assign sel_ab = (avs_address == `OFS_AUTOBUF_CTRL);
    assign sel_ms = (avs_address == `OFS_MODE_STATUS);
    assign sel_im = (avs_address == `OFS_INT_MASK);
    assign sel_sc = (avs_address == `OFS_SYS_CTRL);
    assign sel_sp = (avs_address == `OFS_STACK_PTRS);
    assign sel_st = (avs_address == `OFS_SEQ_STATUS);
    assign be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wdata = avs_writedata[15:0];
    assign seq_status = {9'h000, boot_cfg_ff, host_mode_ff, locked_ff, mrst,
                         state_ff};
    assign rd_mux = sel_ab ? autobuf_ff :
                    sel_ms ? mode_status_ff :
                    sel_im ? imask_ff :
                    sel_sc ? sys_ctrl_ff :
                    sel_sp ? stack_ff :
                    sel_st ? seq_status : 16'h0000;

    function automatic reg16_t merge(input reg16_t old, input reg16_t nw,
                                     input reg16_t be, input reg16_t msk);
        merge = ((old & ~be) | (nw & be)) & msk;
    endfunction : merge

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else if (ce) begin
            ack_ff <= access && !ack_ff;
            rdata_ff <= {16'h0000, rd_mux};
        end
    end

    assign avs_readdata = rdata_ff;

    // Master reset wins over a software write in the same cycle.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            autobuf_ff <= `AUTOBUF_RST;
            mode_status_ff <= `MODE_STATUS_RST;
            imask_ff <= `IMASK_RST;
            sys_ctrl_ff <= `SYS_CTRL_RST;
            stack_ff <= `STACK_EMPTY;
        end else if (ce && mrst) begin
            mode_status_ff <= `MODE_STATUS_RST;
            imask_ff <= `IMASK_RST;
            stack_ff <= `STACK_EMPTY;
        end else if (wr_take) begin
            if (sel_ab) autobuf_ff <= merge(autobuf_ff, wdata, be_mask, `AUTOBUF_MASK);
            if (sel_ms) mode_status_ff <= merge(mode_status_ff, wdata, be_mask, `MODE_STATUS_MASK);
            if (sel_im) imask_ff <= merge(imask_ff, wdata, be_mask, `IMASK_MASK);
            if (sel_sc) sys_ctrl_ff <= merge(sys_ctrl_ff, wdata, be_mask, `SYS_CTRL_MASK);
            if (sel_sp) stack_ff <= merge(stack_ff, wdata, be_mask, 16'hFFFF);
        end
    end

    // ============================================================
    // Straps are looked at only while master reset is active.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            host_mode_ff <= 1'b0;
            boot_cfg_ff <= 1'b0;
        end else if (ce && mrst) begin
            host_mode_ff <= host_strap_s;
            boot_cfg_ff <= boot_strap_s;
        end
    end

    // ============================================================
    // Start-up sequencer.
    seq_state_e nxt_state;
    logic go_boot;
    logic go_fetch;
    logic boot_start_ff;
    logic fetch_start_ff;
    addr14_t fetch_addr_ff;

    assign go_boot = (state_ff == ST_RESET) && !mrst && boot_cfg_ff && bus_req_n_s;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RESET: begin
                if (!mrst) begin
                    nxt_state = go_boot ? ST_BOOT : ST_FETCH;
                end
            end
            ST_BOOT: begin
                if (boot_done) begin
                    nxt_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                nxt_state = ST_RUN;
            end
            ST_RUN: begin
                if (!pwd_n_s) begin
                    nxt_state = ST_PWRDN;
                end
            end
            ST_PWRDN: begin
                if (pwd_n_s) begin
                    nxt_state = ST_RUN;
                end
            end
        endcase
        if (mrst) begin
            nxt_state = ST_RESET;
        end
    end

    assign go_fetch = (state_ff == ST_FETCH) && !mrst;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_RESET;
            boot_start_ff <= 1'b0;
            fetch_start_ff <= 1'b0;
            fetch_addr_ff <= `RESET_VECTOR;
        end else if (ce) begin
            state_ff <= nxt_state;
            boot_start_ff <= go_boot;
            fetch_start_ff <= go_fetch;
            if (go_fetch) begin
                fetch_addr_ff <= `RESET_VECTOR;
            end
        end
    end

    assign boot_start = boot_start_ff;
    assign fetch_start = fetch_start_ff;
    assign fetch_addr = fetch_addr_ff;

    // ============================================================
    // Cycle clock and instruction slots. A single mclk edge cannot show a
    // clock at twice its rate, so four phase bits per input period go to
    // an output serialiser: two full cycle-clock periods per mclk.
    logic clk_dis;
    logic clk_stop;
    logic [3:0] cycle_clock_output_ff;
    logic [1:0] slots_ff;
    logic pwd_ack_ff;

    assign clk_dis = autobuf_ff[`CLOCK_OUTPUT_DISABLE_BIT];
    assign clk_stop = !locked_ff || (state_ff == ST_PWRDN);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cycle_clock_output_ff <= 4'h0;
            slots_ff <= 2'h0;
            pwd_ack_ff <= 1'b0;
        end else if (ce) begin
            cycle_clock_output_ff <= (clk_stop || clk_dis) ? 4'h0 : `CYCLE_CLOCK_PATTERN;
            slots_ff <= (state_ff == ST_RUN && !mrst) ? 2'h3 : 2'h0;
            pwd_ack_ff <= (state_ff == ST_PWRDN);
        end
    end

    assign cycle_clock_output = cycle_clock_output_ff;
    assign instr_slots = slots_ff;
    assign power_down_ack = pwd_ack_ff;

    // ============================================================
    // Interrupt and serial pin sharing.
    logic six_irq;
    logic [5:0] irq_lines;
    logic [5:0] irq_req_ff;

    assign six_irq = sys_ctrl_ff[`SYS_SIX_IRQ_BIT];
    assign irq_lines = {six_irq ? shared_s : 2'h0, irq_s};
    assign sport1_in = six_irq ? 2'h0 : shared_s;
    assign sport1_enable = !six_irq;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_req_ff <= 6'h00;
        end else if (ce) begin
            irq_req_ff <= irq_lines & imask_ff[5:0];
        end
    end

    assign irq_req = irq_req_ff;

    // ============================================================
    // External access with wait states and host addressing.
    logic [2:0] wait_sel;
    logic ws_busy;
    logic ws_done;
    addr14_t addr_pin_ff;

    assign wait_sel = (ext_space == 2'h0) ? sys_ctrl_ff[2:0] :
                      (ext_space == 2'h1) ? sys_ctrl_ff[5:3] :
                      (ext_space == 2'h2) ? sys_ctrl_ff[8:6] : sys_ctrl_ff[11:9];

    wait_stretch u_wait (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .start(ext_req && (state_ff == ST_RUN)),
        .waits(wait_sel),
        .busy(ws_busy),
        .done(ws_done)
    );

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            addr_pin_ff <= 14'h0000;
        end else if (ce && mrst) begin
            // The straps may switch host mode here, so no stale upper address may survive.
            addr_pin_ff <= 14'h0000;
        end else if (ce && ext_req && !ws_busy) begin
            addr_pin_ff <= host_mode_ff ? {13'h0000, ext_addr[0]} : ext_addr;
        end
    end

    assign ext_addr_pin = addr_pin_ff;
    assign ext_addr_oe_n = host_mode_ff ? 14'h3FFE : 14'h0000;
    assign ext_strobe_n = !ws_busy;
    assign ext_ack = ws_done;

    // ============================================================
    // Checks.
    chk_mrst_clears: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && mrst) |=> (mode_status_ff == 16'h0000 && imask_ff == 16'h0000 && stack_ff == 16'h0000))
        else $error("master reset did not clear status, mask and stacks");
    chk_pin_reset: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && !pin_rst_n_s) |-> master_reset ##1 (state_ff == ST_RESET))
        else $error("reset pin did not hold the sequencer in reset");
    chk_cycle_clock_output_gated: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && clk_dis) |=> (cycle_clock_output == 4'h0))
        else $error("cycle clock output not gated by disable bit");
    chk_cycle_clock_output_runs: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && !clk_dis && !clk_stop) |=> (cycle_clock_output == 4'hA))
        else $error("cycle clock output not toggling at cycle rate");
    chk_slot_issue: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && state_ff == ST_RUN && !mrst) |=> (instr_slots == 2'h3))
        else $error("two instruction slots not issued per input period");
    chk_boot_gate: assert property (@(posedge mclk) disable iff (!rstn)
        boot_start |-> $past(boot_cfg_ff && bus_req_n_s && pin_rst_n_s))
        else $error("boot started while not configured or bus requested");
    chk_first_fetch: assert property (@(posedge mclk) disable iff (!rstn)
        fetch_start |-> (fetch_addr == 14'h0000 && state_ff == ST_RUN))
        else $error("first fetch not from address zero");
    chk_lock_holds: assert property (@(posedge mclk) disable iff (!rstn)
        locked_ff |=> locked_ff)
        else $error("clock lock lost after power-up");
    chk_irq_share: assert property (@(posedge mclk) disable iff (!rstn)
        (irq_lines[5:4] != 2'h0) |-> (six_irq && !sport1_enable))
        else $error("shared pins used as interrupts in two-port mode");
    chk_host_addr: assert property (@(posedge mclk) disable iff (!rstn)
        host_mode_ff |-> (ext_addr_oe_n[13:1] == 13'h1FFF && ext_addr_pin[13:1] == 13'h0000))
        else $error("host mode drives upper address lines");
    chk_wait_ack: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && ext_req && state_ff == ST_RUN && !ws_busy && wait_sel == 3'h0)
        |=> ws_busy ##1 ext_ack)
        else $error("zero-wait access not acknowledged on time");

endmodule : dsp_clock_reset_control

// ==== verif/reset_supervisor.sv ====
`timescale 1ns/1ps

// ============================================================
// Reset supervisor at the far side of the reset pin.
module reset_supervisor #(
    parameter int POWERUP_HOLD = 2000,
    parameter int MIN_PULSE = 3
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic pulse_req,
    input wire logic [7:0] pulse_len,
    output logic reset_pin_n
);
    int cnt_ff;

    // Short requests are stretched, since a pulse under the minimum width is never legal.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= POWERUP_HOLD;
            reset_pin_n <= 1'b0;
        end else if (cnt_ff != 0) begin
            cnt_ff <= cnt_ff - 1;
            reset_pin_n <= (cnt_ff == 1);
        end else if (pulse_req) begin
            cnt_ff <= (int'(pulse_len) < MIN_PULSE) ? MIN_PULSE : int'(pulse_len);
            reset_pin_n <= 1'b0;
        end
    end
endmodule : reset_supervisor

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`include "dsp_crc_cfg.svh"

module tb_top;
    import dsp_crc_pkg::*;
    logic mclk, rstn, avs_read, avs_write, bus_request_n, boot_strap, host_strap, power_down_n;
    logic boot_done, ext_req, pulse_req, avs_waitrequest, reset_pin_n, master_reset;
    logic boot_start, fetch_start, power_down_ack, sport1_enable, ext_ack, ext_strobe_n;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable, irq_pins, cycle_clock_output;
    logic [1:0] shared_pins, ext_space, instr_slots, sport1_in;
    logic [7:0] pulse_len;
    logic [5:0] irq_req;
    addr14_t ext_addr, fetch_addr, ext_addr_pin, ext_addr_oe_n;
    int bad_count, compares, seed, cycles, boots, lows, n;

    dsp_clock_reset_control dut (.mclk, .rstn, .ce(1'b1), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .reset_pin_n,
        .bus_request_n, .boot_strap, .host_strap, .power_down_n, .irq_pins, .shared_pins,
        .boot_done, .ext_req, .ext_space, .ext_addr, .master_reset, .boot_start, .fetch_start,
        .fetch_addr, .cycle_clock_output, .instr_slots, .power_down_ack, .irq_req, .sport1_in,
        .sport1_enable, .ext_ack, .ext_strobe_n, .ext_addr_pin, .ext_addr_oe_n);
    reset_supervisor sup (.mclk, .rstn, .pulse_req, .pulse_len, .reset_pin_n);

    // ============================================================
    // Clock, timeout and pulse counters.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (boot_start === 1'b1) boots++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    always @(negedge mclk) if (ext_strobe_n === 1'b0) lows++;

    // ============================================================
    // Shared tasks.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wait_on(input int sel, input int lim, output int cnt);
        logic hit;
        cnt = 0;
        hit = 1'b0;
        while (!hit && cnt < lim) begin
            @(negedge mclk);
            cnt++;
            case (sel)
                0: hit = (master_reset === 1'b0);
                1: hit = (boot_start === 1'b1);
                2: hit = (fetch_start === 1'b1);
                3: hit = (ext_ack === 1'b1);
                4: hit = (power_down_ack === 1'b1);
                default: hit = (reset_pin_n === 1'b1);
            endcase
        end
        if (!hit) begin
            bad_count++;
            $display("unexpected wait %0d expected hit seen none", sel);
        end
        @(posedge mclk);
    endtask : wait_on

    // A request is held until waitrequest is seen low, then released after that edge.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        avs_byteenable <= 4'hf;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : bus

    // Registered outputs are read three edges on, as they stand just before that edge.
    task automatic look();
        repeat (3) @(posedge mclk);
    endtask : look

    task automatic run_up(input logic boot, input logic busy);
        if (boot && !busy) begin
            wait_on(1, 4, n);
            chk("boot_latency", n, 1);
            repeat ($random(seed) & 7) @(posedge mclk);
            boot_done <= 1'b1;
            @(posedge mclk);
            boot_done <= 1'b0;
        end
        wait_on(2, 8, n);
        chk("boot_pulses", boots, boot && !busy);
        chk("fetch_addr", fetch_addr, 14'h0000);
        repeat (2) @(negedge mclk);
        chk("instr_slots", instr_slots, 2'h3);
        chk("cycle_clock", cycle_clock_output, 4'ha);
        @(posedge mclk);
        bus_request_n <= 1'b1;
    endtask : run_up

    task automatic pin_reset(input logic boot, input logic busy, input logic host);
        bus(1'b1, `OFS_MODE_STATUS, 32'h0000_007f & $random(seed));
        bus(1'b1, `OFS_STACK_PTRS, 32'h0000_ffff & $random(seed));
        boot_strap <= boot;
        bus_request_n <= ~busy;
        host_strap <= host;
        pulse_req <= 1'b1;
        pulse_len <= 8'h02 + (8'h0f & $random(seed));
        @(posedge mclk);
        pulse_req <= 1'b0;
        boots = 0;
        wait_on(5, 40, n);
        @(negedge mclk);
        chk("sync_hold", master_reset, 1'b1);
        wait_on(0, 6, n);
        chk("fast_release", n < 5, 1'b1);
        run_up(boot, busy);
        bus(1'b0, `OFS_MODE_STATUS, 32'h0);
        chk("mode_status", rd, 32'h0);
        bus(1'b0, `OFS_STACK_PTRS, 32'h0);
        chk("stacks", rd, 32'h0);
        if (host) chk("host_addr_oe", ext_addr_oe_n, 14'h3ffe);
    endtask : pin_reset

    task automatic ext_acc(input int s, input logic [2:0] w);
        addr14_t a;
        a = 14'($random(seed));
        bus(1'b1, `OFS_SYS_CTRL, 32'(w) << (3 * s));
        ext_space <= 2'(s);
        ext_addr <= a;
        ext_req <= 1'b1;
        lows = 0;
        @(posedge mclk);
        ext_req <= 1'b0;
        wait_on(3, 20, n);
        chk("strobe_len", lows, w + 1);
        chk("ext_addr_pin", ext_addr_pin, host_strap ? {13'h0000, a[0]} : a);
    endtask : ext_acc

    task automatic tally_and_finish();
        $display("counts compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // ============================================================
    // Main sequence.
    initial begin
        seed = 32'h97fe;
        {rstn, avs_read, avs_write, boot_strap, host_strap, boot_done, ext_req, pulse_req} = '0;
        {bus_request_n, power_down_n} = 2'b11;
        {avs_address, avs_writedata, avs_byteenable, irq_pins, shared_pins} = '0;
        {ext_space, ext_addr, pulse_len} = '0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        wait_on(0, 2200, n);
        chk("lock_wait", n >= 1995, 1'b1);
        run_up(1'b0, 1'b0);
        $display("test power_up done");
        for (int i = 0; i < 4; i++) pin_reset(i[0], i[1], i == 3);
        $display("test pin_reset done");
        bus(1'b1, `OFS_AUTOBUF_CTRL, 32'h0000_4000);
        look();
        chk("clock_off", cycle_clock_output, 4'h0);
        bus(1'b0, `OFS_AUTOBUF_CTRL, 32'h0);
        chk("autobuf", rd, 32'h0000_4000);
        bus(1'b1, `OFS_AUTOBUF_CTRL, 32'h0);
        look();
        chk("clock_on", cycle_clock_output, 4'ha);
        bus(1'b1, 5'h18, $random(seed));
        bus(1'b0, 5'h18, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, `OFS_SEQ_STATUS, 32'h0);
        bus(1'b0, `OFS_SEQ_STATUS, 32'h0);
        chk("run_status", rd[4:0], 5'h13);
        $display("test registers done");
        irq_pins <= 4'(($random(seed))) | 4'h1;
        shared_pins <= 2'h3;
        bus(1'b1, `OFS_SYS_CTRL, 32'h0000_1000);
        look();
        chk("one_port", sport1_enable, 1'b0);
        chk("irq_masked", irq_req, 6'h00);
        bus(1'b1, `OFS_INT_MASK, 32'h0000_003f);
        look();
        chk("irq_six", irq_req, {2'h3, irq_pins});
        bus(1'b1, `OFS_SYS_CTRL, 32'h0);
        look();
        chk("two_ports", sport1_enable, 1'b1);
        chk("irq_four", irq_req, {2'h0, irq_pins});
        $display("test pin_share done");
        for (int s = 0; s < 4; s++) ext_acc(s, (s == 0) ? 3'h0 : (s == 3) ? 3'h7 : 3'($random(seed)));
        $display("test wait_states done");
        power_down_n <= 1'b0;
        wait_on(4, 20, n);
        chk("pwr_ack", power_down_ack, 1'b1);
        chk("clock_stopped", cycle_clock_output, 4'h0);
        power_down_n <= 1'b1;
        $display("test power_down done");
        tally_and_finish();
    end
endmodule : tb_top
